// ===== cpm_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// cpu sequencer and interrupt stand-in
// ----------------------------------------
module cpm_cpu_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic opGo,
    input wire logic [1:0] opCode,
    input wire logic cpuCycleEn,
    input wire logic wakeCallIsr,
    output logic sleepExec,
    output logic irqEntry,
    output logic returnFromIrq,
    output logic opBusy
);
    logic [1:0] pend_q; // queued instruction, zero when none

    // an instruction only retires on an executing cycle, so throttling stretches it
    always_ff @(posedge clk_sys)
    begin
        sleepExec <= 1'b0;
        irqEntry <= 1'b0;
        returnFromIrq <= 1'b0;
        if (sys_rst)
        begin
            pend_q <= 2'h0;
        end
        else if (opGo)
        begin
            pend_q <= opCode;
        end
        else if (wakeCallIsr)
        begin
            pend_q <= 2'h2; // vector once the prefetched one has run
        end
        else if (pend_q != 2'h0 && cpuCycleEn)
        begin
            sleepExec <= (pend_q == 2'h1);
            irqEntry <= (pend_q == 2'h2);
            returnFromIrq <= (pend_q == 2'h3);
            pend_q <= 2'h0;
        end
    end

    // busy until the pulse itself has gone
    assign opBusy = (pend_q != 2'h0) | sleepExec | irqEntry | returnFromIrq;
endmodule
`default_nettype wire

// ===== cpm_pkg.sv
package cpm_pkg;

    // ----------------------------------------
    // throttle control register layout
    // ----------------------------------------
    typedef struct packed {
        logic haltSelect;         // sleep instruction enters idle
        logic cpuThrottleEnable;  // one cycle in N runs
        logic recoverOnIrq;       // interrupt entry drops throttle
        logic rethrottleOnReturn; // return from irq restores throttle
        logic rsvd;               // reads zero
        logic [2:0] ratio;        // power-of-two group size code
    } cpm_ctrl_s;

    // ----------------------------------------
    // status register layout
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] rsvdHi;       // reads zero
        logic timeoutFlag;        // timeout status
        logic powerdownFlag;      // powerdown status
        logic rsvdLo;             // reads zero
        logic [1:0] mode;         // current power state
    } cpm_stat_s;

    // power states, gray along run-sleep-stab
    typedef enum logic [1:0] {
        CPM_RUN = 2'h0,
        CPM_SLEEP = 2'h1,
        CPM_STAB = 2'h3,
        CPM_IDLE = 2'h2
    } cpm_state_e;

endpackage

// ===== cpm_power_ctrl.sv
// Overview of operation
// RULE1 - throttle runs one cycle per N-cycle group
// RULE2 - peripherals keep full clock while throttled
// RULE3 - flash prefetch and peripheral clocks continue throttled
// RULE4 - interrupt without recovery keeps throttle on
// RULE5 - interrupt with recovery clears throttle immediately
// RULE6 - return from interrupt may re-set throttle
// RULE7 - sleep instruction enters sleep or idle
// RULE8 - sleep entry clears watchdog count
// RULE9 - sleep entry clears powerdown, sets timeout
// RULE10 - sleep stops cpu clock, oscillators run
// RULE11 - io ports hold drive state in sleep
// RULE12 - reset sources reset, others resume execution
// RULE13 - enabled interrupt wakes regardless of global enable
// RULE14 - after wake call isr only if enabled
// RULE15 - every wake from sleep clears watchdog
// RULE16 - pending interrupt turns sleep into nop
// RULE17 - late interrupt completes sleep then wakes
// RULE18 - low-power regulator adds wake stabilisation delay
// RULE19 - idle halts cpu, peripherals keep clock
// RULE20 - any interrupt ends idle, halt select kept
// RULE21 - idle-ending interrupt restores full speed; the code clears the throttle on idle exit only when recoverOnIrq is set
// RULE22 - idle watchdog wakes, throttle untouched
// RULE23 - ratio code selects power of two
// RULE24 - throttle counter restarts on enable rise
`timescale 1ns/1ns
`default_nettype none
`include "cpm_regs.svh"

module cpm_power_ctrl #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sleepExec,
    input wire logic returnFromIrq,
    input wire logic irqEntry,
    input wire logic irqWakeReq,
    input wire logic irqNoSwitchPend,
    input wire logic globalIrqEnable,
    input wire logic watchdogTimeout,
    input wire logic masterClearPin,
    input wire logic brownoutReset,
    input wire logic porReset,
    output logic cpuCycleEn,
    output logic flashPrefetchEn,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic sysOscPeriphEn,
    output logic ioHold,
    output logic regulatorLowPower,
    output logic watchdogClear,
    output logic watchdogResetReq,
    output logic deviceResetReq,
    output logic wakePulse,
    output logic wakeCallIsr
);
    import cpm_pkg::*;

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    cpm_ctrl_s ctrl_q; // throttle control register
    logic lowPowerSel_q; // regulator low-power select
    logic timeout_q; // timeout flag
    logic powerdown_q; // powerdown flag
    cpm_state_e state_q; // power state
    cpm_state_e state_d;
    logic [CNT_W-1:0] thrCnt_q; // throttle group position
    logic [CNT_W-1:0] thrMask; // group size minus one
    logic thrEnPrev_q; // previous enable, for restart
    logic [7:0] stabCnt_q; // regulator settle counter
    logic ack_q; // bus answer phase
    logic [31:0] rdata_q; // registered read data
    logic [2:0] rstSync1_q; // first sync stage, reset pins
    logic [2:0] rstSync2_q; // second sync stage
    logic sleepEnter; // sleep instruction really executes
    logic wakeSleep; // sleep ends this cycle
    logic wakeIdle; // idle ends this cycle
    logic wdtDone_q; // watchdog clear pulse
    logic wakeDone_q; // wake pulse
    logic callIsr_q; // vector after prefetched instruction
    logic busWr; // write accepted this cycle
    logic busRd; // read accepted this cycle
    cpm_stat_s stat; // status view

    // ----------------------------------------
    // avalon slave: one wait state per access
    // ----------------------------------------

    // answer comes on the second edge of a request
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign busWr = avs_write & ~ack_q & avs_byteenable[0];
    assign busRd = avs_read & ~ack_q;
    assign avs_readdata = rdata_q;

    // answer phase toggles so back-to-back requests each wait once
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read | avs_write) & ~ack_q;
    end

    // status view
    always_comb
    begin
        stat = '0;
        stat.timeoutFlag = timeout_q;
        stat.powerdownFlag = powerdown_q;
        stat.mode = state_q;
    end

    // read mux, unmapped addresses read zero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rdata_q <= '0;
        else if (busRd)
        begin
            unique case (avs_address)
                `CPM_ADDR_CTRL: rdata_q <= {24'h000000, ctrl_q};
                `CPM_ADDR_VREG:
                begin
                    rdata_q <= '0;
                    rdata_q[`CPM_VREG_RSVD_BIT] <= 1'b1;
                    rdata_q[`CPM_VREG_LP_BIT] <= lowPowerSel_q;
                end
                `CPM_ADDR_STAT: rdata_q <= {24'h000000, stat};
                default: rdata_q <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // throttle control register
    // ----------------------------------------

    // software write first, hardware clear next, hardware set last,
    // so a returning set is never lost under a concurrent clear
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ctrl_q <= cpm_ctrl_s'(`CPM_CTRL_RST);
        else
        begin
            if (busWr && avs_address == `CPM_ADDR_CTRL)
            begin
                ctrl_q <= cpm_ctrl_s'(avs_writedata[7:0]);
                ctrl_q.rsvd <= 1'b0;
            end
            // recovery drops the throttle on irq entry or on an interrupt-caused idle exit
            if (ctrl_q.recoverOnIrq && (irqEntry || (wakeIdle && irqWakeReq)))
                ctrl_q.cpuThrottleEnable <= 1'b0; // [RULE5] [RULE21]
            // without recovery the enable is simply left alone [RULE4]
            if (returnFromIrq && ctrl_q.rethrottleOnReturn)
                ctrl_q.cpuThrottleEnable <= 1'b1; // [RULE6]
        end
    end

    // regulator select register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            lowPowerSel_q <= 1'(`CPM_VREG_RST >> `CPM_VREG_LP_BIT);
        else if (busWr && avs_address == `CPM_ADDR_VREG)
            lowPowerSel_q <= avs_writedata[`CPM_VREG_LP_BIT];
    end

    // ----------------------------------------
    // throttle group counter
    // ----------------------------------------

    // code k gives a group of 2^(k+1); code 000 falls back to 1:2
    always_comb
    begin
        thrMask = CNT_W'((9'h001 << (4'(ctrl_q.ratio) + 4'h1)) - 9'h001); // [RULE23]
    end

    // enable history for restart on a fresh throttle
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            thrEnPrev_q <= 1'b0;
        else
            thrEnPrev_q <= ctrl_q.cpuThrottleEnable;
    end

    // count runs only while awake so a group never splits over idle
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            thrCnt_q <= '0;
        else if (ctrl_q.cpuThrottleEnable && !thrEnPrev_q)
            thrCnt_q <= CNT_W'(1); // [RULE24] slot 0 ran on the rise
        else if (!ctrl_q.cpuThrottleEnable || state_q != CPM_RUN)
            thrCnt_q <= '0;
        else
            thrCnt_q <= (thrCnt_q + CNT_W'(1)) & thrMask; // [RULE1]
    end

    // ----------------------------------------
    // clock gating outputs
    // ----------------------------------------

    // cpu executes in slot zero only when throttled
    always_comb
    begin
        cpuCycleEn = (state_q == CPM_RUN) &&
            (!ctrl_q.cpuThrottleEnable || thrCnt_q == '0); // [RULE1]
        // prefetch follows execution as in normal running
        flashPrefetchEn = cpuCycleEn; // [RULE3]
        // cpu clock stops in sleep and settle; idle only halts
        cpuClkEn = (state_q == CPM_RUN) || (state_q == CPM_IDLE); // [RULE10]
        // peripheral quadrature clocks are never throttled
        periphClkEn = 1'b1; // [RULE2] [RULE3] [RULE10]
        // system-oscillator peripherals run in idle, not sleep
        sysOscPeriphEn = (state_q == CPM_RUN) || (state_q == CPM_IDLE); // [RULE19]
        ioHold = (state_q == CPM_SLEEP) || (state_q == CPM_STAB); // [RULE11]
        regulatorLowPower = lowPowerSel_q && (state_q == CPM_SLEEP); // [RULE18]
    end

    // ----------------------------------------
    // power state machine
    // ----------------------------------------

    // an already flagged irq makes the instruction a nop
    assign sleepEnter = sleepExec && state_q == CPM_RUN && !irqNoSwitchPend; // [RULE16]
    // enabled irq wakes, global enable plays no part here
    assign wakeSleep = (state_q == CPM_SLEEP) &&
        (irqWakeReq || watchdogTimeout); // [RULE13] [RULE17]
    assign wakeIdle = (state_q == CPM_IDLE) &&
        (irqWakeReq || watchdogTimeout); // [RULE20] [RULE22]

    // next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CPM_RUN:
                if (sleepEnter)
                    state_d = ctrl_q.haltSelect ? CPM_IDLE : CPM_SLEEP; // [RULE7]
            CPM_SLEEP:
                if (wakeSleep)
                    state_d = lowPowerSel_q ? CPM_STAB : CPM_RUN; // [RULE18]
            CPM_STAB:
                if (stabCnt_q == 8'h00)
                    state_d = CPM_RUN;
            CPM_IDLE:
                if (wakeIdle)
                    state_d = CPM_RUN; // [RULE20] halt select kept
        endcase
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            state_q <= CPM_RUN;
        else
            state_q <= state_d;
    end

    // regulator settle time after a low-power sleep
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            stabCnt_q <= '0;
        else if (wakeSleep)
            stabCnt_q <= 8'(`CPM_STAB_CYC - 1); // [RULE18]
        else if (stabCnt_q != 8'h00)
            stabCnt_q <= stabCnt_q - 8'h01;
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------

    // both flags rise at reset; a nop sleep leaves them alone
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            timeout_q <= `CPM_FLAG_RST;
            powerdown_q <= `CPM_FLAG_RST;
        end
        else if (sleepEnter && !ctrl_q.haltSelect)
        begin
            timeout_q <= 1'b1; // [RULE9] [RULE17]
            powerdown_q <= 1'b0; // [RULE9] [RULE17]
        end
    end

    // ----------------------------------------
    // watchdog and wake handshakes
    // ----------------------------------------

    // clear on sleep entry and on every sleep wake
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            wdtDone_q <= 1'b0;
        else
            wdtDone_q <= (sleepEnter && !ctrl_q.haltSelect) || wakeSleep; // [RULE8] [RULE15]
    end
    assign watchdogClear = wdtDone_q;

    // watchdog reset blocked outside running; in sleep it keeps counting
    assign watchdogResetReq = watchdogTimeout && state_q == CPM_RUN; // [RULE22] [RULE8]

    // wake pulse; isr call follows the prefetched instruction
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wakeDone_q <= 1'b0;
            callIsr_q <= 1'b0;
        end
        else
        begin
            wakeDone_q <= wakeSleep || wakeIdle; // [RULE12]
            callIsr_q <= (wakeSleep || wakeIdle) && irqWakeReq &&
                globalIrqEnable; // [RULE14]
        end
    end
    assign wakePulse = wakeDone_q;
    assign wakeCallIsr = callIsr_q;

    // ----------------------------------------
    // reset wake sources
    // ----------------------------------------

    // pins are asynchronous; the device reset is taken after two flops
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rstSync1_q <= '0;
            rstSync2_q <= '0;
        end
        else
        begin
            rstSync1_q <= {masterClearPin, brownoutReset, porReset};
            rstSync2_q <= rstSync1_q;
        end
    end
    assign deviceResetReq = |rstSync2_q; // [RULE12]

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    throttle_one_slot_a: assert property ( // [RULE1]
        (state_q == CPM_RUN && ctrl_q.cpuThrottleEnable && thrEnPrev_q &&
         thrCnt_q == '0 && ctrl_q.ratio == 3'h1 && !irqEntry && !busWr &&
         !sleepExec) |=> (!cpuCycleEn || !ctrl_q.cpuThrottleEnable) [*3])
        else $error("throttled cpu ran inside its group");

    recover_clear_a: assert property ( // [RULE5]
        (irqEntry && ctrl_q.recoverOnIrq && !returnFromIrq && !busWr)
        |=> !ctrl_q.cpuThrottleEnable)
        else $error("recovery did not drop throttle");

    no_recover_keep_a: assert property ( // [RULE4]
        (irqEntry && !ctrl_q.recoverOnIrq && ctrl_q.cpuThrottleEnable && !busWr)
        |=> ctrl_q.cpuThrottleEnable)
        else $error("throttle lost without recovery");

    return_rethrottle_a: assert property ( // [RULE6]
        (returnFromIrq && ctrl_q.rethrottleOnReturn) |=> ctrl_q.cpuThrottleEnable)
        else $error("return did not restore throttle");

    sleep_flags_a: assert property ( // [RULE9]
        (sleepEnter && !ctrl_q.haltSelect)
        |=> (state_q == CPM_SLEEP && timeout_q && !powerdown_q && watchdogClear))
        else $error("sleep entry flags wrong");

    nop_sleep_a: assert property ( // [RULE16]
        (sleepExec && state_q == CPM_RUN && irqNoSwitchPend)
        |=> (state_q == CPM_RUN && $stable(powerdown_q) && !watchdogClear))
        else $error("pending irq did not make a nop");

    idle_entry_a: assert property ( // [RULE7]
        (sleepEnter && ctrl_q.haltSelect)
        |=> (state_q == CPM_IDLE && cpuClkEn && !cpuCycleEn && sysOscPeriphEn))
        else $error("idle entry wrong");

    idle_wdt_keep_a: assert property ( // [RULE22]
        (wakeIdle && !irqWakeReq && !busWr && !returnFromIrq && !irqEntry)
        |=> ($stable(ctrl_q.cpuThrottleEnable) && state_q == CPM_RUN &&
             !watchdogResetReq ##0 $past(ctrl_q.haltSelect) == ctrl_q.haltSelect))
        else $error("watchdog idle wake disturbed state");

    wake_watchdog_a: assert property ( // [RULE15]
        wakeSleep |=> (watchdogClear && wakePulse))
        else $error("wake did not clear watchdog");

    stab_delay_a: assert property ( // [RULE18]
        (wakeSleep && lowPowerSel_q) |=> (state_q == CPM_STAB && ioHold) ##29
        state_q == CPM_STAB ##1 state_q == CPM_RUN)
        else $error("regulator settle time wrong");

    sleep_hold_a: assert property ( // [RULE11]
        (state_q == CPM_SLEEP) |-> (ioHold && !cpuClkEn && !sysOscPeriphEn && periphClkEn))
        else $error("sleep outputs wrong");

endmodule
`default_nettype wire

// ===== cpm_regs.svh
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CPM_ADDR_CTRL 4'h0
`define CPM_ADDR_VREG 4'h4
`define CPM_ADDR_STAT 4'h8

// ----------------------------------------
// reset values and fixed bits
// ----------------------------------------
`define CPM_CTRL_RST 8'h00
`define CPM_VREG_RST 8'h01
`define CPM_VREG_RSVD_BIT 0
`define CPM_VREG_LP_BIT 1
`define CPM_FLAG_RST 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define CPM_CLK_NS 100
`define CPM_STAB_NS 3000
`define CPM_STAB_CYC ((`CPM_STAB_NS + `CPM_CLK_NS - 1) / `CPM_CLK_NS)

`endif

// ===== cpu_power_mode_controller_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpm_regs.svh"
`define CHK(nm, ex, sn) \
    begin \
        checked++; \
        if ((sn) !== (ex)) \
        begin \
            failures++; \
            $display("ERROR %s expected %0h seen %0h", nm, ex, sn); \
        end \
    end
module cpu_power_mode_controller_bench;
    import cpm_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk_sys = 1'b0, sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rng, v;
    logic irqWakeReq = 1'b0, irqNoSwitchPend = 1'b0, globalIrqEnable = 1'b0;
    logic watchdogTimeout = 1'b0, masterClearPin = 1'b0, brownoutReset = 1'b0;
    logic porReset = 1'b0, opGo = 1'b0, opBusy, global_irq_enable;
    logic [1:0] opCode = 2'h0;
    logic sleepExec, returnFromIrq, irqEntry, cpuCycleEn, flashPrefetchEn, cpuClkEn;
    logic periphClkEn, sysOscPeriphEn, ioHold, regulatorLowPower, watchdogClear;
    logic watchdogResetReq, deviceResetReq, wakePulse, wakeCallIsr;
    int failures = 0, checked = 0, cycles = 0, wdcCnt = 0, n, r, w0;

    always #50 clk_sys = ~clk_sys; // 10 MHz

    cpm_power_ctrl i_cpm_power_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sleepExec(sleepExec), .returnFromIrq(returnFromIrq), .irqEntry(irqEntry),
        .irqWakeReq(irqWakeReq), .irqNoSwitchPend(irqNoSwitchPend),
        .globalIrqEnable(globalIrqEnable), .watchdogTimeout(watchdogTimeout),
        .masterClearPin(masterClearPin), .brownoutReset(brownoutReset), .porReset(porReset),
        .cpuCycleEn(cpuCycleEn), .flashPrefetchEn(flashPrefetchEn), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .sysOscPeriphEn(sysOscPeriphEn), .ioHold(ioHold),
        .regulatorLowPower(regulatorLowPower), .watchdogClear(watchdogClear),
        .watchdogResetReq(watchdogResetReq), .deviceResetReq(deviceResetReq),
        .wakePulse(wakePulse), .wakeCallIsr(wakeCallIsr));

    cpm_cpu_model i_cpm_cpu_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .opGo(opGo),
        .opCode(opCode), .cpuCycleEn(cpuCycleEn), .wakeCallIsr(wakeCallIsr),
        .sleepExec(sleepExec), .irqEntry(irqEntry), .returnFromIrq(returnFromIrq),
        .opBusy(opBusy));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // group size from ratio code, code zero read as 1:2
    function automatic int groupOf(input int code);
        return (code == 0) ? 2 : (1 << (code + 1));
    endfunction

    // watchdog clears, counted by nba
    always @(posedge clk_sys)
    begin
        if (watchdogClear === 1'b1)
            wdcCnt <= wdcCnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            test_done();
        end
    end

    // one avalon access, held until waitrequest is seen low
    task automatic busAcc(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                          input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do
        begin
            @(posedge clk_sys);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // upper write bits random, they must be dropped
    task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] x;
        busAcc(1'b1, a, {xs() >> 8, d}, 4'hf, x);
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] x;
        busAcc(1'b0, a, 32'h0, 4'h0, x);
        `CHK("readdata", {24'h0, e}, x)
    endtask

    // hand one instruction to the cpu model and wait till it retired
    task automatic cpuOp(input logic [1:0] c);
        @(posedge clk_sys);
        opGo <= 1'b1;
        opCode <= c;
        @(posedge clk_sys);
        opGo <= 1'b0;
        do
        begin
            @(posedge clk_sys);
        end
        while (opBusy !== 1'b0);
    endtask

    task automatic waitWake(output int k);
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (wakePulse !== 1'b1);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rng = 32'h28fc;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // reset values, refused writes, unmapped place
        rdChk(4'h0, 8'h00);
        rdChk(4'h4, 8'h01);
        rdChk(4'h8, 8'h18);
        rdChk(4'hc, 8'h00);
        wrReg(4'h8, 8'hff);
        rdChk(4'h8, 8'h18);
        busAcc(1'b1, 4'h0, 32'hff, 4'h0, v);
        rdChk(4'h0, 8'h00);
        v = xs();
        wrReg(4'h0, v[7:0]);
        rdChk(4'h0, v[7:0] & 8'hf7);
        wrReg(4'h4, v[15:8]);
        rdChk(4'h4, {6'h0, v[9], 1'b1});
        // every ratio code: group minus one idle cycles, then one executing cycle
        for (r = 0; r < 8; r++)
        begin
            wrReg(4'h0, 8'h00);
            wrReg(4'h0, 8'h40 | r[7:0]);
            repeat (groupOf(r) - 1)
            begin
                @(posedge clk_sys);
                `CHK("cpuCycleEn", 1'b0, cpuCycleEn)
                `CHK("flashPrefetchEn", 1'b0, flashPrefetchEn)
                `CHK("periphClkEn", 1'b1, periphClkEn)
            end
            @(posedge clk_sys);
            `CHK("cpuCycleEn", 1'b1, cpuCycleEn)
        end
        // interrupt entry and return under throttle
        wrReg(4'h0, 8'h41);
        cpuOp(2'h2);
        rdChk(4'h0, 8'h41);
        wrReg(4'h0, 8'h71);
        cpuOp(2'h2);
        rdChk(4'h0, 8'h31);
        repeat (4)
        begin
            @(posedge clk_sys);
            `CHK("cpuCycleEn", 1'b1, cpuCycleEn)
        end
        cpuOp(2'h3);
        rdChk(4'h0, 8'h71);
        // sleep, woken by irq with low-power regulator, irq, watchdog
        for (r = 0; r < 3; r++)
        begin
            wrReg(4'h0, 8'h00);
            wrReg(4'h4, (r == 0) ? 8'h03 : 8'h01);
            v = xs();
            global_irq_enable = v[0];
            w0 = wdcCnt;
            cpuOp(2'h1);
            @(posedge clk_sys);
            `CHK("ioHold", 1'b1, ioHold)
            `CHK("cpuClkEn", 1'b0, cpuClkEn)
            `CHK("periphClkEn", 1'b1, periphClkEn)
            `CHK("sysOscPeriphEn", 1'b0, sysOscPeriphEn)
            `CHK("regulatorLowPower", (r == 0), regulatorLowPower)
            rdChk(4'h8, 8'h11);
            `CHK("watchdogClears", w0 + 1, wdcCnt)
            globalIrqEnable <= global_irq_enable;
            if (r == 2)
                watchdogTimeout <= 1'b1;
            else
                irqWakeReq <= 1'b1;
            @(posedge clk_sys);
            `CHK("watchdogResetReq", 1'b0, watchdogResetReq)
            watchdogTimeout <= 1'b0;
            waitWake(n);
            `CHK("wakeCallIsr", global_irq_enable & (r != 2), wakeCallIsr)
            while (cpuClkEn !== 1'b1)
            begin
                @(posedge clk_sys);
                n++;
            end
            if (r == 0)
                `CHK("slowWake", 1'b1, n >= `CPM_STAB_CYC)
            else
                `CHK("fastWake", 1'b1, n <= 3)
            irqWakeReq <= 1'b0;
            cpuOp(2'h0);
            `CHK("watchdogClears", w0 + 2, wdcCnt)
            `CHK("ioHold", 1'b0, ioHold)
            `CHK("deviceResetReq", 1'b0, deviceResetReq)
        end
        // pending enabled interrupt turns sleep into nothing
        irqNoSwitchPend <= 1'b1;
        irqWakeReq <= 1'b1;
        w0 = wdcCnt;
        cpuOp(2'h1);
        repeat (2) @(posedge clk_sys);
        `CHK("ioHold", 1'b0, ioHold)
        rdChk(4'h8, 8'h10);
        `CHK("watchdogClears", w0, wdcCnt)
        irqNoSwitchPend <= 1'b0;
        irqWakeReq <= 1'b0;
        // idle, left by watchdog then by interrupt
        wrReg(4'h0, 8'hf1);
        cpuOp(2'h1);
        @(posedge clk_sys);
        `CHK("sysOscPeriphEn", 1'b1, sysOscPeriphEn)
        `CHK("cpuCycleEn", 1'b0, cpuCycleEn)
        rdChk(4'h8, 8'h12);
        watchdogTimeout <= 1'b1;
        @(posedge clk_sys);
        `CHK("watchdogResetReq", 1'b0, watchdogResetReq)
        watchdogTimeout <= 1'b0;
        waitWake(n);
        rdChk(4'h0, 8'hf1);
        cpuOp(2'h1);
        rdChk(4'h8, 8'h12);
        globalIrqEnable <= 1'b0;
        irqWakeReq <= 1'b1;
        waitWake(n);
        `CHK("wakeCallIsr", 1'b0, wakeCallIsr)
        irqWakeReq <= 1'b0;
        rdChk(4'h0, 8'hb1);
        // watchdog in run asks for reset
        wrReg(4'h0, 8'h00);
        watchdogTimeout <= 1'b1;
        @(posedge clk_sys);
        `CHK("watchdogResetReq", 1'b1, watchdogResetReq)
        watchdogTimeout <= 1'b0;
        // each reset pin after its two-flop synchroniser
        for (r = 0; r < 3; r++)
        begin
            masterClearPin <= (r == 0);
            brownoutReset <= (r == 1);
            porReset <= (r == 2);
            repeat (3) @(posedge clk_sys);
            `CHK("deviceResetReq", 1'b1, deviceResetReq)
            masterClearPin <= 1'b0;
            brownoutReset <= 1'b0;
            porReset <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        test_done();
    end
endmodule
`default_nettype wire
